//--- hw/uht_pkg.sv
package uht_pkg;

  // number of host ports served by this block
  localparam int UHT_HOSTS = 2;

  // register indices (byte address = 4 * index on the bus)
  localparam logic [15:0] UHT_IDX_CTRL   [UHT_HOSTS] = '{16'hC080, 16'hC0A0};
  localparam logic [15:0] UHT_IDX_COUNT  [UHT_HOSTS] = '{16'hC084, 16'hC0A4};
  localparam logic [15:0] UHT_IDX_SELECT [UHT_HOSTS] = '{16'hC086, 16'hC0A6};
  localparam logic [15:0] UHT_IDX_RESULT [UHT_HOSTS] = '{16'hC088, 16'hC0A8};

  // reset values
  localparam logic [15:0] UHT_RST_WORD   = 16'h0000;
  localparam logic [31:0] UHT_RST_RDATA  = 32'h0000_0000;
  localparam logic [9:0]  UHT_RST_COUNT  = 10'h000;
  localparam logic [7:0]  UHT_RST_SELECT = 8'h00;
  localparam logic [6:0]  UHT_RST_ADDR   = 7'h00;

  // transaction control bit positions
  localparam int UHT_CT_ARM  = 0;
  localparam int UHT_CT_ISO  = 4;
  localparam int UHT_CT_SYNC = 5;
  localparam int UHT_CT_SEQ  = 6;
  localparam int UHT_CT_PRE  = 7;

  // endpoint status bit positions
  localparam int UHT_ST_ACK   = 0;
  localparam int UHT_ST_ERR   = 1;
  localparam int UHT_ST_TMO   = 2;
  localparam int UHT_ST_TOG   = 3;
  localparam int UHT_ST_LENX  = 5;
  localparam int UHT_ST_NAK   = 6;
  localparam int UHT_ST_STALL = 7;
  localparam int UHT_ST_UNDER = 10;
  localparam int UHT_ST_OVER  = 11;

  // packet kind field codes in selector bits 7..4
  localparam logic [3:0] UHT_PID_SETUP = 4'hD;
  localparam logic [3:0] UHT_PID_IN    = 4'h9;
  localparam logic [3:0] UHT_PID_OUT   = 4'h1;
  localparam logic [3:0] UHT_PID_SOF   = 4'h5;
  localparam logic [3:0] UHT_PID_PRE   = 4'hC;
  localparam logic [3:0] UHT_PID_NAK   = 4'hA;
  localparam logic [3:0] UHT_PID_STALL = 4'hE;
  localparam logic [3:0] UHT_PID_DATA0 = 4'h3;
  localparam logic [3:0] UHT_PID_DATA1 = 4'hB;

  // upper fill of the length difference on an overflow
  localparam logic [5:0] UHT_OVF_FILL = 6'h3F;

  typedef enum logic [3:0] {
    UHT_K_SETUP,
    UHT_K_IN,
    UHT_K_OUT,
    UHT_K_SOF,
    UHT_K_PRE,
    UHT_K_NAK,
    UHT_K_STALL,
    UHT_K_DATA0,
    UHT_K_DATA1,
    UHT_K_OTHER
  } uht_kind_t;

endpackage

//--- hw/uht_result.sv
`timescale 1ns/1ns
`default_nettype none
module uht_result
  import uht_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        iso,
  input  wire logic        ack_seen,
  input  wire logic        nak,
  input  wire logic        stall,
  input  wire logic        timeout,
  input  wire logic        error,
  input  wire logic        data_rx,
  input  wire logic        rx_toggle,
  input  wire logic [10:0] rx_len,
  input  wire logic [9:0]  exp_count,
  output logic      [15:0] status,
  output logic      [15:0] diff
);

  logic [15:0] exp16;
  logic [15:0] len16;
  logic [15:0] sub16;
  logic        over;
  logic        under;

  // length comparison against the 10-bit expected count
  assign exp16 = {6'h00, exp_count};                     // [R24]
  assign len16 = {5'h00, rx_len};
  assign sub16 = exp16 - len16;
  assign over  = data_rx & (len16 > exp16);              // [R1]
  assign under = data_rx & (len16 < exp16);              // [R2]

  // status word assembly, reserved bits zero
  always_comb begin
    status = UHT_RST_WORD;
    status[UHT_ST_OVER]  = over;                         // [R1]
    status[UHT_ST_UNDER] = under;                        // [R2]
    status[UHT_ST_LENX]  = over | under;                 // [R3]
    status[UHT_ST_STALL] = stall;                        // [R5]
    status[UHT_ST_NAK]   = nak;                          // [R6]
    status[UHT_ST_TOG]   = data_rx & rx_toggle & ~error; // [R7] [R8]
    status[UHT_ST_TMO]   = timeout;                      // [R10]
    status[UHT_ST_ERR]   = error;                        // [R11]
    status[UHT_ST_ACK]   = iso ? ~(error | timeout | nak | stall)
                               : ack_seen;               // [R12]
  end

  // signed difference: negative fill on overflow, shortfall on underflow
  always_comb begin
    if (over) begin
      diff = {UHT_OVF_FILL, sub16[9:0]};                 // [R20]
    end else if (under) begin
      diff = sub16;                                      // [R21]
    end else begin
      diff = UHT_RST_WORD;                               // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  over_flag_a: assert property ( // [R1]
    status[UHT_ST_OVER] == (data_rx && rx_len > {1'b0, exp_count}))
    else $error("overflow flag wrong");
  under_flag_a: assert property ( // [R2]
    status[UHT_ST_UNDER] == (data_rx && rx_len < {1'b0, exp_count}))
    else $error("underflow flag wrong");
  len_exc_a: assert property ( // [R3]
    status[UHT_ST_LENX] == (data_rx && rx_len != {1'b0, exp_count}))
    else $error("length exception wrong");
  toggle_err_a: assert property ( // [R8]
    error |-> !status[UHT_ST_TOG] && status[UHT_ST_ERR])
    else $error("toggle not forced low");
  err_len_a: assert property ( // [R11]
    !error |-> !status[UHT_ST_ERR])
    else $error("error set by length");
  diff_over_a: assert property ( // [R20]
    status[UHT_ST_OVER] |-> diff[15:10] == 6'h3F
    && diff[9:0] == exp_count - rx_len[9:0])
    else $error("overflow diff wrong");
  diff_under_a: assert property ( // [R21]
    status[UHT_ST_UNDER] |-> diff + len16 == exp16)
    else $error("underflow diff wrong");
  iso_ack_a: assert property ( // [R12]
    iso && (error || timeout) |-> !status[UHT_ST_ACK])
    else $error("iso ack on failure");

endmodule
`default_nettype wire

//--- hw/uht_host_status.sv
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [R1] Overflow bit 11 set when last packet longer than expected count.
// [R2] Underflow bit 10 set when last packet shorter than expected count.
// [R3] Length-exception bit 5 set when received length differs either way.
// [R4] Software checks overflow and underflow only after length exception.
// [R5] Stall bit 7 set when the peripheral answered with STALL.
// [R6] NAK bit 6 set when the peripheral answered with NAK.
// [R7] Bit 3 records last received toggle, 1 for DATA1; valid with ack.
// [R8] Toggle bit forced low on a transaction error, error bit set.
// [R9] Software itself checks the data toggle sequence.
// [R10] Timeout bit 2 set when the peripheral answers too slowly.
// [R11] Error bit 1 for other failures; length faults leave it alone.
// [R12] Ack bit 0: ACK seen, or iso transaction completed successfully.
// [R13] Selector holds packet kind and endpoint for the next transaction.
// [R14] Kind codes: SETUP 1101, IN 1001, OUT 0001, SOF 0101.
// [R15] Kind codes: PRE 1100, NAK 1010, STALL 1110, DATA0 0011, DATA1 1011.
// [R16] ACK and NAK handshakes generated automatically, not from selector.
// [R17] Endpoint number from selector bits 3..0, sixteen endpoints.
// [R18] Count result holds expected count minus received length.
// [R19] Software trusts count result only with length exception, no error.
// [R20] Overflow reported as two's complement, bits 15..10 all ones.
// [R21] Underflow reported as full 16-bit count of missing bytes.
// [R22] Seven-bit target address in bits 6..0 used for next transaction.
// [R23] Software writes zero to reserved bits.
// [R24] Expected byte count is ten bits, limits and judges lengths.
// [R25] Arm bit clears itself when the armed transaction completes.
// [R26] Status bits and count result update together at completion.
module uht_host_status
  import uht_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [15:0]           avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  output logic      [1:0]            eng_start,
  output logic      [1:0][3:0]       eng_pid,
  output var uht_kind_t [1:0]        eng_kind,
  output logic      [1:0][3:0]       eng_endpoint,
  output logic      [1:0][6:0]       eng_dev_addr,
  output logic      [1:0][9:0]       eng_count,
  output logic      [1:0]            eng_iso,
  output logic      [1:0]            eng_toggle,
  output logic      [1:0]            eng_preamble,
  output logic      [1:0]            eng_sync,
  output logic      [1:0]            eng_auto_hs,
  input  wire logic [1:0]            eng_done,
  input  wire logic [1:0]            eng_ack_seen,
  input  wire logic [1:0]            eng_nak,
  input  wire logic [1:0]            eng_stall,
  input  wire logic [1:0]            eng_timeout,
  input  wire logic [1:0]            eng_error,
  input  wire logic [1:0]            eng_data_rx,
  input  wire logic [1:0]            eng_rx_toggle,
  input  wire logic [1:0][10:0]      eng_rx_len
);

  ////////////////////////////////////////////////////////////////////////////

  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              req;
  logic              wr_acc;
  logic [1:0]        arm_reg;
  logic [1:0]        iso_reg;
  logic [1:0]        sync_reg;
  logic [1:0]        seq_reg;
  logic [1:0]        pre_reg;
  logic [1:0]        start_reg;
  logic [9:0]        count_reg  [UHT_HOSTS];
  logic [7:0]        select_reg [UHT_HOSTS];
  logic [6:0]        daddr_reg  [UHT_HOSTS];
  logic [15:0]       status_reg [UHT_HOSTS];
  logic [15:0]       diff_reg   [UHT_HOSTS];
  uht_kind_t         kind_reg   [UHT_HOSTS];
  logic [15:0]       res_status [UHT_HOSTS];
  logic [15:0]       res_diff   [UHT_HOSTS];
  logic [15:0]       ctrl_new   [UHT_HOSTS];
  logic [15:0]       wr_word    [UHT_HOSTS];
  logic [1:0]        wr_ctrl;
  logic [1:0]        wr_count;
  logic [1:0]        wr_sel;
  logic [1:0]        wr_addr;
  logic [1:0]        arm_set;
  logic [1:0]        done_acc;

  // byte-lane merge of a 16-bit register with write data
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = old;
    if (be[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  // packet kind field decode
  function automatic uht_kind_t decode_kind(input logic [3:0] p);
    unique case (p)
      UHT_PID_SETUP: decode_kind = UHT_K_SETUP;   // [R14]
      UHT_PID_IN:    decode_kind = UHT_K_IN;      // [R14]
      UHT_PID_OUT:   decode_kind = UHT_K_OUT;     // [R14]
      UHT_PID_SOF:   decode_kind = UHT_K_SOF;     // [R14]
      UHT_PID_PRE:   decode_kind = UHT_K_PRE;     // [R15]
      UHT_PID_NAK:   decode_kind = UHT_K_NAK;     // [R15]
      UHT_PID_STALL: decode_kind = UHT_K_STALL;   // [R15]
      UHT_PID_DATA0: decode_kind = UHT_K_DATA0;   // [R15]
      UHT_PID_DATA1: decode_kind = UHT_K_DATA1;   // [R15]
      default:       decode_kind = UHT_K_OTHER;
    endcase
  endfunction

  // readable view of the control register
  function automatic logic [15:0] ctrl_view(input logic pre, input logic seq,
                                            input logic syn, input logic iso,
                                            input logic arm);
    ctrl_view = UHT_RST_WORD;
    ctrl_view[UHT_CT_PRE]  = pre;
    ctrl_view[UHT_CT_SEQ]  = seq;
    ctrl_view[UHT_CT_SYNC] = syn;
    ctrl_view[UHT_CT_ISO]  = iso;
    ctrl_view[UHT_CT_ARM]  = arm;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // bus handshake: one wait cycle, answer on the second cycle
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_acc          = avs_write & ack_reg;
  assign avs_readdata    = rdata_reg;

  // wait-state flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // address decode and write qualifiers per host
  always_comb begin
    for (int h = 0; h < UHT_HOSTS; h++) begin
      wr_ctrl[h]  = wr_acc && (avs_address == UHT_IDX_CTRL[h]);
      wr_count[h] = wr_acc && (avs_address == UHT_IDX_COUNT[h]);
      wr_sel[h]   = wr_acc && (avs_address == UHT_IDX_SELECT[h]);
      wr_addr[h]  = wr_acc && (avs_address == UHT_IDX_RESULT[h]);
      wr_word[h]  = merge(UHT_RST_WORD, avs_writedata, avs_byteenable);
      ctrl_new[h] = merge(ctrl_view(pre_reg[h], seq_reg[h], sync_reg[h],
                                    iso_reg[h], 1'b0),
                          avs_writedata, avs_byteenable);
      done_acc[h] = eng_done[h] & arm_reg[h];
      arm_set[h]  = wr_ctrl[h] & ctrl_new[h][UHT_CT_ARM]
                    & (~arm_reg[h] | done_acc[h]);
    end
  end

  // read mux; write-only registers share offsets with read-only ones
  always_comb begin
    rdata_next = UHT_RST_RDATA;
    for (int h = 0; h < UHT_HOSTS; h++) begin
      if (avs_address == UHT_IDX_CTRL[h]) begin
        rdata_next[15:0] = ctrl_view(pre_reg[h], seq_reg[h], sync_reg[h],
                                     iso_reg[h], arm_reg[h]);
      end
      if (avs_address == UHT_IDX_COUNT[h]) begin
        rdata_next[9:0] = count_reg[h];
      end
      if (avs_address == UHT_IDX_SELECT[h]) begin
        rdata_next[15:0] = status_reg[h];
      end
      if (avs_address == UHT_IDX_RESULT[h]) begin
        rdata_next[15:0] = diff_reg[h];
      end
    end
  end

  // read data captured in the wait cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= UHT_RST_RDATA;
    end else if (avs_read && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // transaction control: arm launches, completion disarms, set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arm_reg   <= 2'b00;
      iso_reg   <= 2'b00;
      sync_reg  <= 2'b00;
      seq_reg   <= 2'b00;
      pre_reg   <= 2'b00;
      start_reg <= 2'b00;
    end else begin
      for (int h = 0; h < UHT_HOSTS; h++) begin
        start_reg[h] <= arm_set[h];
        if (wr_ctrl[h]) begin
          iso_reg[h]  <= ctrl_new[h][UHT_CT_ISO];
          sync_reg[h] <= ctrl_new[h][UHT_CT_SYNC];
          seq_reg[h]  <= ctrl_new[h][UHT_CT_SEQ];
          pre_reg[h]  <= ctrl_new[h][UHT_CT_PRE];
        end
        if (arm_set[h]) begin
          arm_reg[h] <= 1'b1;
        end else if (done_acc[h]) begin
          arm_reg[h] <= 1'b0;                            // [R25]
        end
      end
    end
  end

  // expected count, selector and target address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int h = 0; h < UHT_HOSTS; h++) begin
        count_reg[h]  <= UHT_RST_COUNT;
        select_reg[h] <= UHT_RST_SELECT;
        daddr_reg[h]  <= UHT_RST_ADDR;
        kind_reg[h]   <= UHT_K_OTHER;
      end
    end else begin
      for (int h = 0; h < UHT_HOSTS; h++) begin
        if (wr_count[h]) begin
          count_reg[h] <= wr_word[h][9:0];               // [R24]
        end
        if (wr_sel[h]) begin
          select_reg[h] <= wr_word[h][7:0];              // [R13] [R17]
          kind_reg[h]   <= decode_kind(wr_word[h][7:4]); // [R14] [R15]
        end
        if (wr_addr[h]) begin
          daddr_reg[h] <= wr_word[h][6:0];               // [R22]
        end
      end
    end
  end

  // result computation per host
  for (genvar g = 0; g < UHT_HOSTS; g++) begin : g_res
    uht_result u_res (
      .clock     (clock),
      .rst       (rst),
      .iso       (iso_reg[g]),
      .ack_seen  (eng_ack_seen[g]),
      .nak       (eng_nak[g]),
      .stall     (eng_stall[g]),
      .timeout   (eng_timeout[g]),
      .error     (eng_error[g]),
      .data_rx   (eng_data_rx[g]),
      .rx_toggle (eng_rx_toggle[g]),
      .rx_len    (eng_rx_len[g]),
      .exp_count (count_reg[g]),
      .status    (res_status[g]),
      .diff      (res_diff[g])
    );
  end

  // status and difference loaded together on completion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int h = 0; h < UHT_HOSTS; h++) begin
        status_reg[h] <= UHT_RST_WORD;
        diff_reg[h]   <= UHT_RST_WORD;
      end
    end else begin
      for (int h = 0; h < UHT_HOSTS; h++) begin
        if (done_acc[h]) begin
          status_reg[h] <= res_status[h];                // [R26]
          diff_reg[h]   <= res_diff[h];                  // [R18] [R26]
        end
      end
    end
  end

  // serial engine request outputs straight from registers
  always_comb begin
    for (int h = 0; h < UHT_HOSTS; h++) begin
      eng_start[h]    = start_reg[h];
      eng_pid[h]      = select_reg[h][7:4];              // [R13]
      eng_kind[h]     = kind_reg[h];
      eng_endpoint[h] = select_reg[h][3:0];              // [R17]
      eng_dev_addr[h] = daddr_reg[h];                    // [R22]
      eng_count[h]    = count_reg[h];                    // [R24]
      eng_iso[h]      = iso_reg[h];
      eng_toggle[h]   = seq_reg[h];
      eng_preamble[h] = pre_reg[h];
      eng_sync[h]     = sync_reg[h];
      eng_auto_hs[h]  = ~iso_reg[h];                     // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  bus_answer_a: assert property (
    req |-> ##[0:1] !avs_waitrequest)
    else $error("bus answer late");

  for (genvar g = 0; g < UHT_HOSTS; g++) begin : g_chk
    arm_clear_a: assert property ( // [R25]
      arm_reg[g] && eng_done[g] && !wr_ctrl[g] |=> !arm_reg[g])
      else $error("arm not cleared");
    status_load_a: assert property ( // [R26]
      arm_reg[g] && eng_done[g] |=> status_reg[g] == $past(res_status[g])
      && diff_reg[g] == $past(res_diff[g]))
      else $error("status not loaded");
    status_hold_a: assert property ( // [R26]
      !(arm_reg[g] && eng_done[g]) |=> $stable(status_reg[g]))
      else $error("status changed idle");
    sel_take_a: assert property ( // [R13] [R17]
      wr_sel[g] && avs_byteenable[0] |=> eng_pid[g] == $past(avs_writedata[7:4])
      && eng_endpoint[g] == $past(avs_writedata[3:0]))
      else $error("selector not taken");
    kind_tok_a: assert property ( // [R14]
      eng_pid[g] == 4'hD |-> eng_kind[g] == UHT_K_SETUP)
      else $error("setup decode wrong");
    kind_in_a: assert property ( // [R14]
      eng_pid[g] == 4'h9 |-> eng_kind[g] == UHT_K_IN)
      else $error("in decode wrong");
    kind_data_a: assert property ( // [R15]
      eng_pid[g] == 4'hB |-> eng_kind[g] == UHT_K_DATA1)
      else $error("data1 decode wrong");
    addr_take_a: assert property ( // [R22]
      wr_addr[g] && avs_byteenable[0]
      |=> eng_dev_addr[g] == $past(avs_writedata[6:0]))
      else $error("address not taken");
    count_take_a: assert property ( // [R24]
      wr_count[g] && avs_byteenable[1:0] == 2'b11
      |=> eng_count[g] == $past(avs_writedata[9:0]))
      else $error("count not taken");
    auto_hs_a: assert property ( // [R16]
      eng_auto_hs[g] == !eng_iso[g])
      else $error("handshake mode wrong");
    start_once_a: assert property (
      eng_start[g] |=> !eng_start[g] && arm_reg[g] || eng_done[g])
      else $error("start not a pulse");

    arm_done_c: cover property (eng_start[g] ##[1:20] done_acc[g]);
    overflow_c: cover property (done_acc[g] && res_status[g][UHT_ST_OVER]);
    underflow_c: cover property (done_acc[g] && res_status[g][UHT_ST_UNDER]);
    rearm_c: cover property (done_acc[g] && arm_set[g]);
  end

endmodule
`default_nettype wire

//--- verif/uht_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
module uht_engine_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [1:0]  start,
  input  wire logic [4:0]  cmd_flags,
  input  wire logic        cmd_data,
  input  wire logic        cmd_tog,
  input  wire logic [10:0] cmd_len,
  input  wire logic [7:0]  cmd_delay,
  output logic [1:0]       done,
  output logic [1:0]       ack_seen,
  output logic [1:0]       nak,
  output logic [1:0]       stall,
  output logic [1:0]       timeout,
  output logic [1:0]       error,
  output logic [1:0]       data_rx,
  output logic [1:0]       rx_toggle,
  output logic [1:0][10:0] rx_len
);
  logic       busy_reg;
  logic       host_reg;
  logic [7:0] wait_reg;
  logic       fire;
  logic [4:0] fl;
  // one transaction at a time, answered after the commanded latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      host_reg <= 1'b0;
      wait_reg <= 8'h00;
    end else if (start != 2'b00) begin
      busy_reg <= 1'b1;
      host_reg <= start[1];
      wait_reg <= cmd_delay;
    end else if (busy_reg && wait_reg != 8'h00) begin
      wait_reg <= wait_reg - 8'h01;
    end else begin
      busy_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // results hold only in the done cycle, inverted at all other times
  assign fire      = busy_reg && wait_reg == 8'h00;
  assign done      = fire ? (host_reg ? 2'b10 : 2'b01) : 2'b00;
  assign fl        = fire ? cmd_flags : ~cmd_flags;
  assign ack_seen  = {2{fl[4]}};
  assign nak       = {2{fl[3]}};
  assign stall     = {2{fl[2]}};
  assign timeout   = {2{fl[1]}};
  assign error     = {2{fl[0]}};
  assign data_rx   = {2{fire ? cmd_data : ~cmd_data}};
  assign rx_toggle = {2{fire ? cmd_tog : ~cmd_tog}};
  assign rx_len    = {2{fire ? cmd_len : ~cmd_len}};
endmodule
`default_nettype wire

//--- verif/uht_host_status_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module uht_host_status_tb_top
  import uht_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [4:0] cmd_flags = 5'h00;
  logic cmd_data = 1'b0;
  logic cmd_tog = 1'b0;
  logic [10:0] cmd_len = 11'h000;
  logic [7:0] cmd_delay = 8'h00;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic [1:0] st, iso, tgl, pre, syn, ahs, dn, ak, nk, sl, tm, er, dr, rt;
  wire logic [1:0][3:0] pid, ep;
  wire uht_kind_t [1:0] kind;
  wire logic [1:0][6:0] dev;
  wire logic [1:0][9:0] cnt;
  wire logic [1:0][10:0] rl;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  localparam logic [3:0] CODES [10] = '{UHT_PID_SETUP, UHT_PID_IN,
    UHT_PID_OUT, UHT_PID_SOF, UHT_PID_PRE, UHT_PID_NAK, UHT_PID_STALL,
    UHT_PID_DATA0, UHT_PID_DATA1, 4'h2};
  localparam uht_kind_t KINDS [10] = '{UHT_K_SETUP, UHT_K_IN, UHT_K_OUT,
    UHT_K_SOF, UHT_K_PRE, UHT_K_NAK, UHT_K_STALL, UHT_K_DATA0, UHT_K_DATA1,
    UHT_K_OTHER};
  uht_host_status i_uht_host_status (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .eng_start(st), .eng_pid(pid), .eng_kind(kind), .eng_endpoint(ep),
    .eng_dev_addr(dev), .eng_count(cnt), .eng_iso(iso), .eng_toggle(tgl),
    .eng_preamble(pre), .eng_sync(syn), .eng_auto_hs(ahs), .eng_done(dn),
    .eng_ack_seen(ak), .eng_nak(nk), .eng_stall(sl), .eng_timeout(tm),
    .eng_error(er), .eng_data_rx(dr), .eng_rx_toggle(rt), .eng_rx_len(rl));
  uht_engine_model i_uht_engine_model (.clock(clock), .rst(rst), .start(st),
    .cmd_flags(cmd_flags), .cmd_data(cmd_data), .cmd_tog(cmd_tog),
    .cmd_len(cmd_len), .cmd_delay(cmd_delay), .done(dn), .ack_seen(ak),
    .nak(nk), .stall(sl), .timeout(tm), .error(er), .data_rx(dr),
    .rx_toggle(rt), .rx_len(rl));
  // clock and hang guard
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  // arm one transaction, wait for the arm bit to drop, judge results
  task automatic run_txn(input int h, input logic is, input logic [9:0] c,
    input logic [4:0] fl, input logic da, input logic tg,
    input logic [10:0] ln, input logic [7:0] dl, input logic [15:0] es,
    input logic [15:0] ed);
    logic [15:0] q;
    int n;
    cmd_flags <= fl;
    cmd_data <= da;
    cmd_tog <= tg;
    cmd_len <= ln;
    cmd_delay <= dl;
    bus(1'b1, UHT_IDX_COUNT[h], {6'h00, c}, q);
    chk({6'h00, cnt[h]}, {6'h00, c});
    bus(1'b1, UHT_IDX_CTRL[h], {11'h000, is, 4'h1}, q);
    n = 0;
    q = 16'h0001;
    while (q[0] === 1'b1 && n < 40) begin
      bus(1'b0, UHT_IDX_CTRL[h], 16'h0000, q);
      n++;
    end
    chk(q & 16'h0001, 16'h0000);
    bus(1'b0, UHT_IDX_SELECT[h], 16'h0000, q);
    chk(q, es);
    if (q[5] === 1'b1 && q[1] === 1'b0) begin
      bus(1'b0, UHT_IDX_RESULT[h], 16'h0000, q);
      chk(q, ed);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] q;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // reset values and an unmapped place
    for (int h = 0; h < 2; h++) begin
      bus(1'b0, UHT_IDX_SELECT[h], 16'h0000, q);
      chk(q, 16'h0000);
      bus(1'b0, UHT_IDX_RESULT[h], 16'h0000, q);
      chk(q, 16'h0000);
    end
    bus(1'b1, 16'h1234, 16'hFFFF, q);
    bus(1'b0, 16'h1234, 16'h0000, q);
    chk(q, 16'h0000);
    // every packet kind code, endpoints counting down from 15
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, UHT_IDX_SELECT[1], {8'h00, CODES[i], 4'(15 - i)}, q);
      chk({12'h000, pid[1]}, {12'h000, CODES[i]});
      chk({12'h000, kind[1]}, {12'h000, KINDS[i]});
      chk({12'h000, ep[1]}, 16'(15 - i));
    end
    bus(1'b1, UHT_IDX_RESULT[1], 16'h007F, q);
    chk({9'h000, dev[1]}, 16'h007F);
    // preamble, sequence and sync bits reach the engine and read back
    bus(1'b1, UHT_IDX_CTRL[1], 16'h00E0, q);
    chk({13'h0000, pre[1], tgl[1], syn[1]}, 16'h0007);
    bus(1'b0, UHT_IDX_CTRL[1], 16'h0000, q);
    chk(q, 16'h00E0);
    run_txn(0, 0, 10, 5'h10, 1, 1, 13, 0, 16'h0829, 16'hFFFD);
    run_txn(0, 0, 10, 5'h10, 1, 0, 4, 20, 16'h0421, 16'h0006);
    run_txn(1, 0, 1023, 5'h10, 1, 0, 1024, 3, 16'h0821, 16'hFFFF);
    run_txn(1, 0, 1023, 5'h10, 1, 0, 0, 1, 16'h0421, 16'h03FF);
    run_txn(1, 0, 8, 5'h01, 1, 1, 12, 2, 16'h0822, 16'h0000);
    run_txn(0, 0, 8, 5'h08, 0, 0, 8, 5, 16'h0040, 16'h0000);
    run_txn(0, 0, 8, 5'h04, 0, 0, 8, 1, 16'h0080, 16'h0000);
    run_txn(1, 0, 8, 5'h02, 0, 0, 8, 9, 16'h0004, 16'h0000);
    run_txn(0, 1, 8, 5'h00, 1, 1, 8, 4, 16'h0009, 16'h0000);
    chk({15'h0000, ahs[0]}, 16'h0000);
    run_txn(0, 1, 8, 5'h02, 0, 0, 8, 2, 16'h0004, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
